// file: hdl/sfcf_frame.v
`timescale 1ns/100ps
`include "sfcf_map.vh"
// Contract
// - Inputs sampled on rising link clock edges, outputs change on falling ones.
// - A cycle runs falling edge to falling edge; mode 0 starts at select fall.
// - Frame opens with an 8-bit instruction, one bit per rise on lane 0.
// - Instruction may add a 24 or 32 bit address, chosen by instruction.
// - Instruction sets later phase width: one, two or four lanes.
// - Lane 0 holds the least significant bit; groups go most significant first.
// - Dual/quad output commands take the address on lane 0 only.
// - Dual/quad I/O commands take address and return data on all lanes used.
// - Mode bits after the address may make the next frame skip its instruction.
// - Write data is sampled on rising edges.
// - First read bits driven on the fall ending the last dummy cycle.
// - Read data continues until select rises; master may stop anytime.
// - Frames without read data must end on a multiple of eight clocks.
// - Bits most significant first; bytes in rising address order.
// - During an embedded operation array reads are ignored; few commands allowed.
// - A status read reports busy and failure of the embedded operation.
// - With select high, inputs are ignored and lanes are not driven.
// - A select fall is needed before the first frame after power-up.
module sfcf_frame (
    input wire clock,
    input wire srst,
    input wire spi_clk,
    input wire select_n,
    input wire data_lane_0_in,
    input wire data_lane_1_in,
    input wire data_lane_2_in,
    input wire data_lane_3_in,
    output reg data_lane_0_out,
    output reg data_lane_1_out,
    output reg data_lane_2_out,
    output reg data_lane_3_out,
    output reg data_lane_0_oe,
    output reg data_lane_1_oe,
    output reg data_lane_2_oe,
    output reg data_lane_3_oe,
    input wire op_busy,
    input wire op_fail,
    input wire [7:0] rd_data,
    input wire rd_valid,
    output reg rd_ready,
    output reg cmd_start,
    output reg cmd_done,
    output reg cmd_reject,
    output reg [7:0] cmd_opcode,
    output reg [31:0] cmd_addr,
    output reg [7:0] cmd_mode,
    output reg [31:0] data_addr,
    output wire [7:0] wr_byte,
    output wire wr_valid,
    input wire wr_ready,
    output reg wr_overrun
);
    localparam S_IDLE = 9'h001;
    localparam S_INST = 9'h002;
    localparam S_ADDR = 9'h004;
    localparam S_MODE = 9'h008;
    localparam S_DUMMY = 9'h010;
    localparam S_RDATA = 9'h020;
    localparam S_WDATA = 9'h040;
    localparam S_WAIT = 9'h080;
    localparam S_IGNORE = 9'h100;

    function [14:0] sfcf_dec;
        input [7:0] op;
        begin
            case (op)
                `SFCF_OP_READ: sfcf_dec = {1'b0, 1'b1, `SFCF_DUMMY_0, `SFCF_DIR_READ, 1'b0,
                    `SFCF_W1, `SFCF_W1, 1'b0, 1'b1};
                `SFCF_OP_FAST_READ: sfcf_dec = {1'b0, 1'b1, `SFCF_DUMMY_FAST, `SFCF_DIR_READ,
                    1'b0, `SFCF_W1, `SFCF_W1, 1'b0, 1'b1};
                `SFCF_OP_READ_A32: sfcf_dec = {1'b0, 1'b1, `SFCF_DUMMY_0, `SFCF_DIR_READ,
                    1'b0, `SFCF_W1, `SFCF_W1, 1'b1, 1'b1};
                `SFCF_OP_DUAL_OUT: sfcf_dec = {1'b0, 1'b1, `SFCF_DUMMY_FAST, `SFCF_DIR_READ,
                    1'b0, `SFCF_W2, `SFCF_W1, 1'b0, 1'b1};
                `SFCF_OP_QUAD_OUT: sfcf_dec = {1'b0, 1'b1, `SFCF_DUMMY_FAST, `SFCF_DIR_READ,
                    1'b0, `SFCF_W4, `SFCF_W1, 1'b0, 1'b1};
                `SFCF_OP_DUAL_IO: sfcf_dec = {1'b0, 1'b1, `SFCF_DUMMY_0, `SFCF_DIR_READ,
                    1'b1, `SFCF_W2, `SFCF_W2, 1'b0, 1'b1};
                `SFCF_OP_QUAD_IO: sfcf_dec = {1'b0, 1'b1, `SFCF_DUMMY_QIO, `SFCF_DIR_READ,
                    1'b1, `SFCF_W4, `SFCF_W4, 1'b0, 1'b1};
                `SFCF_OP_PROGRAM: sfcf_dec = {1'b0, 1'b0, `SFCF_DUMMY_0, `SFCF_DIR_WRITE,
                    1'b0, `SFCF_W1, `SFCF_W1, 1'b0, 1'b1};
                `SFCF_OP_QUAD_PROGRAM: sfcf_dec = {1'b0, 1'b0, `SFCF_DUMMY_0, `SFCF_DIR_WRITE,
                    1'b0, `SFCF_W4, `SFCF_W1, 1'b0, 1'b1};
                `SFCF_OP_STATUS: sfcf_dec = {1'b1, 1'b0, `SFCF_DUMMY_0, `SFCF_DIR_READ,
                    1'b0, `SFCF_W1, `SFCF_W1, 1'b0, 1'b0};
                default: sfcf_dec = `SFCF_DEC_NONE;
            endcase
        end
    endfunction

    // Phase length in lane groups
    function [5:0] sfcf_groups;
        input [8:0] st;
        input [14:0] d;
        begin
            case (st)
                S_INST: sfcf_groups = `SFCF_INST_BITS;
                S_ADDR: sfcf_groups = (d[`SFCF_D_A32] ? `SFCF_ADDR32_BITS : `SFCF_ADDR24_BITS)
                    >> d[`SFCF_D_AW];
                S_MODE: sfcf_groups = `SFCF_BYTE_BITS >> d[`SFCF_D_AW];
                S_DUMMY: sfcf_groups = {2'b00, d[`SFCF_D_DUMMY]};
                S_WDATA: sfcf_groups = `SFCF_BYTE_BITS >> d[`SFCF_D_DW];
                default: sfcf_groups = 6'h00;
            endcase
        end
    endfunction

    function [8:0] sfcf_after_mode;
        input [14:0] d;
        begin
            if (d[`SFCF_D_DUMMY] != `SFCF_DUMMY_0) begin
                sfcf_after_mode = S_DUMMY;
            end else if (d[`SFCF_D_DIR] == `SFCF_DIR_READ) begin
                sfcf_after_mode = S_RDATA;
            end else if (d[`SFCF_D_DIR] == `SFCF_DIR_WRITE) begin
                sfcf_after_mode = S_WDATA;
            end else begin
                sfcf_after_mode = S_WAIT;
            end
        end
    endfunction

    // Three-stage pin capture; a change counts once stages two and three agree
    wire [5:0] pin_raw;
    wire [5:0] pin_f;
    genvar gi;
    assign pin_raw = {select_n, spi_clk, data_lane_3_in, data_lane_2_in, data_lane_1_in,
        data_lane_0_in};
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_pin
            reg s1;
            reg s2;
            reg s3;
            reg f;
            always @(posedge clock) begin
                // Select resets low so a frame needs a real fall after reset
                if (srst) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    f <= 1'b0;
                end else begin
                    s1 <= pin_raw[gi];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        f <= s2;
                    end
                end
            end
            assign pin_f[gi] = f;
        end
    endgenerate

    reg sck_q;
    reg sel_q;
    reg [8:0] state;
    reg [14:0] dec_q;
    reg [31:0] sh;
    reg [7:0] rsh;
    reg [5:0] cnt;
    reg [2:0] rise_cnt;
    reg any_rise;
    reg cont;
    reg data_first;
    reg push;
    reg [7:0] push_byte;
    wire fifo_in_ready;
    wire selected = ~pin_f[5];
    wire sck_rise = pin_f[4] & ~sck_q & selected;
    wire sck_fall = ~pin_f[4] & sck_q & selected;
    wire sel_fall = ~pin_f[5] & sel_q;
    wire sel_rise = pin_f[5] & ~sel_q;
    wire [3:0] lanes = pin_f[3:0];
    wire is_status = (cmd_opcode == `SFCF_OP_STATUS);
    wire [7:0] status_byte = {6'h00, op_fail, op_busy};

    reg [1:0] in_w;
    reg [31:0] shifted;
    reg [7:0] new_op;
    reg [14:0] next_dec;
    reg [8:0] next_st;
    reg [7:0] out_src;
    reg [7:0] next_rsh;

    always @* begin
        case (state)
            S_ADDR: in_w = dec_q[`SFCF_D_AW];
            S_MODE: in_w = dec_q[`SFCF_D_AW];
            S_WDATA: in_w = dec_q[`SFCF_D_DW];
            default: in_w = `SFCF_W1;
        endcase
        case (in_w)
            `SFCF_W2: shifted = {sh[29:0], lanes[1], lanes[0]};
            `SFCF_W4: shifted = {sh[27:0], lanes[3:0]};
            default: shifted = {sh[30:0], lanes[0]};
        endcase
        new_op = shifted[7:0];
        next_dec = (state == S_INST) ? sfcf_dec(new_op) : dec_q;
        case (state)
            S_INST: begin
                if (op_busy & ~next_dec[`SFCF_D_BUSY_OK]) begin
                    next_st = S_IGNORE;
                end else if (next_dec[`SFCF_D_ADDR]) begin
                    next_st = S_ADDR;
                end else begin
                    next_st = sfcf_after_mode(next_dec);
                end
            end
            S_ADDR: next_st = dec_q[`SFCF_D_MODE] ? S_MODE : sfcf_after_mode(dec_q);
            S_MODE: next_st = sfcf_after_mode(dec_q);
            S_DUMMY: next_st = (dec_q[`SFCF_D_DIR] == `SFCF_DIR_READ) ? S_RDATA : S_WDATA;
            default: next_st = state;
        endcase
        if (cnt == 6'h00) begin
            out_src = is_status ? status_byte : (rd_valid ? rd_data : `SFCF_IDLE_BYTE);
        end else begin
            out_src = rsh;
        end
        case (dec_q[`SFCF_D_DW])
            `SFCF_W2: next_rsh = {out_src[5:0], 2'b00};
            `SFCF_W4: next_rsh = {out_src[3:0], 4'h0};
            default: next_rsh = {out_src[6:0], 1'b0};
        endcase
    end

    always @(posedge clock) begin
        if (srst) begin
            sck_q <= 1'b0;
            sel_q <= 1'b0;
            state <= S_IDLE;
            dec_q <= `SFCF_DEC_NONE;
            sh <= 32'h00000000;
            rsh <= 8'h00;
            cnt <= 6'h00;
            rise_cnt <= 3'h0;
            any_rise <= 1'b0;
            cont <= 1'b0;
            data_first <= 1'b1;
            push <= 1'b0;
            push_byte <= 8'h00;
            rd_ready <= 1'b0;
            cmd_start <= 1'b0;
            cmd_done <= 1'b0;
            cmd_reject <= 1'b0;
            cmd_opcode <= 8'h00;
            cmd_addr <= 32'h00000000;
            cmd_mode <= 8'h00;
            data_addr <= 32'h00000000;
            wr_overrun <= 1'b0;
            {data_lane_3_out, data_lane_2_out, data_lane_1_out, data_lane_0_out} <= 4'h0;
            {data_lane_3_oe, data_lane_2_oe, data_lane_1_oe, data_lane_0_oe} <= 4'h0;
        end else begin
            sck_q <= pin_f[4];
            sel_q <= pin_f[5];
            push <= 1'b0;
            rd_ready <= 1'b0;
            cmd_start <= 1'b0;
            cmd_done <= 1'b0;
            cmd_reject <= 1'b0;
            wr_overrun <= push & ~fifo_in_ready;
            if (sel_rise) begin
                // Frame closes: state, bit counter and drivers back to idle; decode word is kept
                state <= S_IDLE;
                cnt <= 6'h00;
                {data_lane_3_oe, data_lane_2_oe, data_lane_1_oe, data_lane_0_oe} <= 4'h0;
                case (state)
                    S_RDATA: cmd_done <= 1'b1;
                    S_WAIT, S_WDATA: begin
                        cmd_done <= any_rise & (rise_cnt == 3'h0);
                        cmd_reject <= ~(any_rise & (rise_cnt == 3'h0));
                    end
                    S_INST, S_ADDR, S_MODE, S_DUMMY: cmd_reject <= 1'b1;
                    default: cmd_reject <= 1'b0;
                endcase
            end else if (sel_fall) begin
                rise_cnt <= 3'h0;
                any_rise <= 1'b0;
                data_first <= 1'b1;
                if (cont & op_busy) begin
                    state <= S_IGNORE;
                end else if (cont) begin
                    state <= S_ADDR;
                    cnt <= sfcf_groups(S_ADDR, dec_q);
                end else begin
                    state <= S_INST;
                    cnt <= `SFCF_INST_BITS;
                end
            end else if (sck_rise) begin
                rise_cnt <= rise_cnt + 3'h1;
                any_rise <= 1'b1;
                if ((state & (S_INST | S_ADDR | S_MODE | S_DUMMY | S_WDATA)) != 9'h000) begin
                    sh <= shifted;
                    cnt <= cnt - 6'h01;
                end
                if ((state & (S_INST | S_ADDR | S_MODE | S_DUMMY)) != 9'h000 && cnt == 6'h01) begin
                    state <= next_st;
                    dec_q <= next_dec;
                    cnt <= sfcf_groups(next_st, next_dec);
                    cmd_start <= (next_st & (S_RDATA | S_WDATA | S_WAIT)) != 9'h000;
                    if (state == S_INST) begin
                        cmd_opcode <= new_op;
                        cont <= 1'b0;
                    end
                    if (state == S_ADDR) begin
                        cmd_addr <= dec_q[`SFCF_D_A32] ? shifted : {8'h00, shifted[23:0]};
                        data_addr <= dec_q[`SFCF_D_A32] ? shifted : {8'h00, shifted[23:0]};
                    end
                    if (state == S_MODE) begin
                        cmd_mode <= shifted[7:0];
                        cont <= shifted[7:4] == `SFCF_CONT_KEY;
                    end
                end
                if (state == S_WDATA && cnt == 6'h01) begin
                    push <= 1'b1;
                    push_byte <= shifted[7:0];
                    cnt <= sfcf_groups(S_WDATA, dec_q);
                    data_first <= 1'b0;
                    if (!data_first) begin
                        data_addr <= data_addr + 32'h00000001;
                    end
                end
            end else if (sck_fall && state == S_RDATA) begin
                // Falling edge after the last header rise drives the first group
                rsh <= next_rsh;
                if (cnt == 6'h00) begin
                    cnt <= sfcf_groups(S_WDATA, dec_q) - 6'h01;
                    rd_ready <= ~is_status & rd_valid;
                    data_first <= 1'b0;
                    if (!data_first) begin
                        data_addr <= data_addr + 32'h00000001;
                    end
                end else begin
                    cnt <= cnt - 6'h01;
                end
                case (dec_q[`SFCF_D_DW])
                    `SFCF_W2: begin
                        {data_lane_3_out, data_lane_2_out} <= 2'b00;
                        {data_lane_1_out, data_lane_0_out} <= out_src[7:6];
                        {data_lane_3_oe, data_lane_2_oe, data_lane_1_oe, data_lane_0_oe} <= 4'h3;
                    end
                    `SFCF_W4: begin
                        {data_lane_3_out, data_lane_2_out, data_lane_1_out, data_lane_0_out}
                            <= out_src[7:4];
                        {data_lane_3_oe, data_lane_2_oe, data_lane_1_oe, data_lane_0_oe} <= 4'hf;
                    end
                    default: begin
                        {data_lane_3_out, data_lane_2_out, data_lane_0_out} <= 3'b000;
                        data_lane_1_out <= out_src[7];
                        {data_lane_3_oe, data_lane_2_oe, data_lane_1_oe, data_lane_0_oe} <= 4'h2;
                    end
                endcase
            end
        end
    end

    // Link cannot be stalled, so a full buffer drops the byte and flags it
    sfcf_fifo #(
        .WIDTH(`SFCF_FIFO_WIDTH),
        .DEPTH(`SFCF_FIFO_DEPTH)
    ) u_wr_fifo (
        .clock(clock),
        .srst(srst),
        .in_data(push_byte),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .out_data(wr_byte),
        .out_valid(wr_valid),
        .out_ready(wr_ready)
    );
endmodule // sfcf_frame

// file: hdl/sfcf_map.vh
`ifndef SFCF_MAP_VH
`define SFCF_MAP_VH

// Bit counts of the frame
`define SFCF_INST_BITS 6'd8
`define SFCF_BYTE_BITS 6'd8
`define SFCF_ADDR24_BITS 6'd24
`define SFCF_ADDR32_BITS 6'd32

// Write byte buffer shape
`define SFCF_FIFO_WIDTH 8
`define SFCF_FIFO_DEPTH 16

// Instruction codes
`define SFCF_OP_READ 8'h03
`define SFCF_OP_FAST_READ 8'h0b
`define SFCF_OP_READ_A32 8'h13
`define SFCF_OP_DUAL_OUT 8'h3b
`define SFCF_OP_QUAD_OUT 8'h6b
`define SFCF_OP_DUAL_IO 8'hbb
`define SFCF_OP_QUAD_IO 8'heb
`define SFCF_OP_PROGRAM 8'h02
`define SFCF_OP_QUAD_PROGRAM 8'h32
`define SFCF_OP_STATUS 8'h05

// Decode word fields
`define SFCF_D_ADDR 0
`define SFCF_D_A32 1
`define SFCF_D_AW 3:2
`define SFCF_D_DW 5:4
`define SFCF_D_MODE 6
`define SFCF_D_DIR 8:7
`define SFCF_D_DUMMY 12:9
`define SFCF_D_ARRAY 13
`define SFCF_D_BUSY_OK 14
`define SFCF_DEC_NONE 15'h0000

// Lane width codes
`define SFCF_W1 2'h0
`define SFCF_W2 2'h1
`define SFCF_W4 2'h2

// Data direction codes
`define SFCF_DIR_NONE 2'h0
`define SFCF_DIR_READ 2'h1
`define SFCF_DIR_WRITE 2'h2

// Dummy cycle counts
`define SFCF_DUMMY_0 4'h0
`define SFCF_DUMMY_QIO 4'h4
`define SFCF_DUMMY_FAST 4'h8

// Mode bits upper nibble that keeps the next frame implied
`define SFCF_CONT_KEY 4'ha

// Status byte fields
`define SFCF_STAT_BUSY 0
`define SFCF_STAT_FAIL 1

// Filled byte while no read byte is offered
`define SFCF_IDLE_BYTE 8'hff

`endif

// file: hdl/sfcf_fifo.v
`timescale 1ns/100ps
module sfcf_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16
) (
    input wire clock,
    input wire srst,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output reg [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    localparam AW = $clog2(DEPTH);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    reg have_out;
    wire push;
    wire pop;
    wire load;

    // Output stage counts toward the depth
    assign in_ready = (count + {{AW{1'b0}}, have_out}) != DEPTH[AW:0];
    assign out_valid = have_out;
    assign push = in_valid & in_ready;
    // Output stage refills whenever it is empty or being drained
    assign load = (count != {(AW+1){1'b0}}) & (~have_out | out_ready);
    assign pop = load;

    always @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            have_out <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
                out_data <= mem[rd_ptr];
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
            if (load) begin
                have_out <= 1'b1;
            end else if (out_ready) begin
                have_out <= 1'b0;
            end
        end
    end
endmodule // sfcf_fifo

// file: dv/sfcf_frame_assertions.sv
`timescale 1ns/100ps
`include "sfcf_map.vh"
module sfcf_frame_assertions (
    input wire clock,
    input wire srst,
    input wire spi_clk,
    input wire select_n,
    input wire data_lane_0_oe,
    input wire data_lane_1_oe,
    input wire data_lane_2_oe,
    input wire data_lane_3_oe,
    input wire data_lane_1_out,
    input wire rd_ready,
    input wire cmd_start,
    input wire cmd_done,
    input wire cmd_reject,
    input wire wr_overrun,
    input wire wr_valid,
    input wire wr_ready,
    input wire [7:0] wr_byte,
    input wire [7:0] cmd_opcode,
    input wire [31:0] cmd_addr
);
    reg [3:0] idle_cnt;
    always @(posedge clock) begin
        if (srst || !select_n)
            idle_cnt <= 4'h0;
        else if (idle_cnt != 4'hf)
            idle_cnt <= idle_cnt + 4'h1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    lanes_released_a: assert property (
        idle_cnt > 4'h6 |-> !(data_lane_0_oe || data_lane_1_oe || data_lane_2_oe || data_lane_3_oe))
        else $error("lane driven while deselected");
    quad_group_a: assert property (
        !(data_lane_0_oe && !data_lane_1_oe) && data_lane_2_oe == data_lane_3_oe
        && !(data_lane_2_oe && !data_lane_0_oe)) else $error("lane enables form no group");
    out_after_fall_a: assert property (
        data_lane_1_oe && $past(data_lane_1_oe) && $changed(data_lane_1_out)
        |-> !$past(spi_clk, 3) || !$past(spi_clk, 4) || !$past(spi_clk, 5) || !$past(spi_clk, 6))
        else $error("output moved without a clock fall");
    end_pulse_a: assert property (
        cmd_done || cmd_reject |-> $past(select_n, 2) && !(cmd_done && cmd_reject))
        else $error("frame end outside deselect");
    start_in_frame_a: assert property (
        cmd_start |-> !select_n && !$past(select_n, 8)) else $error("header end outside frame");
    read_spacing_a: assert property (
        rd_ready |=> !rd_ready [*8]) else $error("read bytes too close");
    wr_hold_a: assert property (
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_byte)) else $error("write byte lost");
    overrun_frame_a: assert property (
        wr_overrun |-> !$past(select_n, 3)) else $error("overrun outside frame");
    addr_narrow_a: assert property (
        cmd_start && cmd_opcode == `SFCF_OP_READ |=> cmd_addr[31:24] == 8'h00)
        else $error("narrow address has upper bits");
    cover property (cmd_done);
    cover property (cmd_reject);
    cover property (wr_overrun);
    cover property (data_lane_2_oe);
endmodule // sfcf_frame_assertions

// file: dv/sfcf_host.sv
`timescale 1ns/100ps
module sfcf_host (
    input wire clock,
    input wire [3:0] lane,
    output reg spi_clk,
    output reg select_n,
    output reg [3:0] drv,
    output reg [3:0] drv_oe
);
    reg mode3;
    initial begin
        spi_clk = 1'h0;
        select_n = 1'h1;
        drv = 4'h0;
        drv_oe = 4'h0;
        mode3 = 1'h0;
    end
    task open(input m);
        begin
            mode3 = m;
            spi_clk = m;
            @(negedge clock);
            select_n = 1'h0;
            drv_oe = 4'h1;
            repeat (8) @(negedge clock);
        end
    endtask
    // Samples at the end of the high phase: device output lags the fall by 4-5 clocks
    task xfer(input [31:0] v, input integer n, input integer w, input rd, output [31:0] got);
        integer i;
        begin
            got = 32'h0;
            drv_oe = rd ? 4'h0 : (w == 4 ? 4'hf : (w == 2 ? 4'h3 : 4'h1));
            for (i = n - w; i >= 0; i = i - w) begin
                spi_clk = 1'h0;
                drv = 4'((v >> i) & ((1 << w) - 1));
                repeat (4) @(negedge clock);
                spi_clk = 1'h1;
                repeat (4) @(negedge clock);
                got = (got << w) | 32'(w == 1 ? {3'h0, lane[1]} : lane & 4'((1 << w) - 1));
            end
        end
    endtask
    task close;
        begin
            spi_clk = mode3;
            repeat (4) @(negedge clock);
            select_n = 1'h1;
            drv_oe = 4'h0;
            repeat (10) @(negedge clock);
        end
    endtask
endmodule // sfcf_host

// file: dv/sfcf_frame_bench.sv
`timescale 1ns/100ps
module sfcf_frame_bench;
    reg clock = 1'h0, srst = 1'h1, op_busy = 1'h0, op_fail = 1'h0, wr_ready = 1'h0;
    reg rd_valid = 1'h1, flick = 1'h0, stall = 1'h1, saw_oe = 1'h0;
    reg [7:0] rd_data = 8'h00;
    reg [23:0] seed = 24'h016d32;
    reg [31:0] got, a;
    reg [7:0] sentq[$], wrq[$], bq[$];
    integer n_fail = 0, compares = 0, n_start = 0, n_done = 0, n_reject = 0, n_over = 0, k;
    wire spi_clk, select_n, rd_ready, cmd_start, cmd_done, cmd_reject, wr_valid, wr_overrun;
    wire [3:0] drv, drv_oe, dout, doe, lane;
    wire [7:0] cmd_opcode, cmd_mode, wr_byte;
    wire [31:0] cmd_addr, data_addr;
    // Released lanes 0 and 1 float, so they toggle; lanes 2 and 3 have pull-ups
    assign lane = (doe & dout) | (~doe & drv_oe & drv) | (~doe & ~drv_oe & {2'h3, flick, flick});
    sfcf_host host (.clock(clock), .lane(lane), .spi_clk(spi_clk), .select_n(select_n),
        .drv(drv), .drv_oe(drv_oe));
    sfcf_frame sfcf_frame_inst (.clock(clock), .srst(srst), .spi_clk(spi_clk),
        .select_n(select_n), .data_lane_0_in(lane[0]), .data_lane_1_in(lane[1]),
        .data_lane_2_in(lane[2]), .data_lane_3_in(lane[3]), .data_lane_0_out(dout[0]),
        .data_lane_1_out(dout[1]), .data_lane_2_out(dout[2]), .data_lane_3_out(dout[3]),
        .data_lane_0_oe(doe[0]), .data_lane_1_oe(doe[1]), .data_lane_2_oe(doe[2]),
        .data_lane_3_oe(doe[3]), .op_busy(op_busy), .op_fail(op_fail), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .cmd_start(cmd_start), .cmd_done(cmd_done),
        .cmd_reject(cmd_reject), .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr),
        .cmd_mode(cmd_mode), .data_addr(data_addr), .wr_byte(wr_byte), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_overrun(wr_overrun));
    function [23:0] lfsr(input [23:0] s);
        lfsr = {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
    endfunction
    initial forever #10 clock = ~clock;
    always @(posedge clock) begin
        if (cmd_start === 1'h1) n_start = n_start + 1;
        if (cmd_done === 1'h1) n_done = n_done + 1;
        if (cmd_reject === 1'h1) n_reject = n_reject + 1;
        if (wr_overrun === 1'h1) n_over = n_over + 1;
        if (doe !== 4'h0) saw_oe = 1'h1;
        if (wr_valid === 1'h1 && wr_ready) wrq.push_back(wr_byte);
    end
    always @(negedge clock) begin
        seed <= lfsr(seed);
        flick <= ~flick;
        wr_ready <= !stall && seed[0];
        if (rd_ready === 1'h1) begin
            rd_data <= seed[7:0];
            sentq.push_back(seed[7:0]);
        end
    end
    task check(input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("Error at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task counts(input [31:0] e);
        check({n_start[7:0], n_done[7:0], n_reject[7:0], n_over[7:0]}, e);
    endtask
    task start(input m);
        begin
            sentq.delete();
            sentq.push_back(rd_data);
            host.open(m);
        end
    endtask
    task read_tail(input integer w);
        begin
            host.xfer(0, 16, w, 1, got);
            host.close;
            check(got[15:0], {sentq[0], sentq[1]});
        end
    endtask
    task give_verdict;
        begin
            $display("compares %0d mismatches %0d", compares, n_fail);
            if (n_fail == 0 && compares > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        #400000;
        n_fail = n_fail + 1;
        give_verdict;
    end
    initial begin
        repeat (20) @(negedge clock);
        srst = 1'h0;
        repeat (8) @(negedge clock);
        check(doe, 4'h0);
        a = 32'(seed);
        start(0);
        host.xfer(8'h03, 8, 1, 0, got);
        host.xfer(a, 24, 1, 0, got);
        read_tail(1);
        check(cmd_addr, a);
        // Parking fall in mode 0 opens a third byte
        check(data_addr, a + 2);
        counts(32'h01010000);
        start(1);
        host.xfer(8'h6b, 8, 1, 0, got);
        host.xfer(a, 24, 1, 0, got);
        host.xfer(0, 8, 1, 1, got);
        read_tail(4);
        check(cmd_opcode, 8'h6b);
        start(0);
        host.xfer(8'hbb, 8, 1, 0, got);
        host.xfer(a, 24, 2, 0, got);
        host.xfer(8'ha5, 8, 2, 0, got);
        read_tail(2);
        check(cmd_mode, 8'ha5);
        a = 32'(lfsr(seed));
        start(0);
        host.xfer(a, 24, 2, 0, got);
        host.xfer(0, 8, 2, 0, got);
        read_tail(2);
        check({cmd_opcode, cmd_addr[23:0]}, {8'hbb, a[23:0]});
        counts(32'h04040000);
        host.open(0);
        host.xfer(8'h02, 8, 1, 0, got);
        host.xfer(a, 24, 1, 0, got);
        for (k = 0; k < 17; k = k + 1) begin
            bq.push_back(seed[7:0]);
            host.xfer(seed[7:0], 8, 1, 0, got);
        end
        host.close;
        counts(32'h05050001);
        stall = 1'h0;
        for (k = 0; k < 600 && wrq.size() < 16; k = k + 1) @(negedge clock);
        repeat (40) @(negedge clock);
        check(wrq.size(), 16);
        for (k = 0; k < 16; k = k + 1) check(wrq[k], bq[k]);
        host.open(0);
        host.xfer(8'h02, 8, 1, 0, got);
        host.xfer(a, 24, 1, 0, got);
        host.xfer(5'h15, 5, 1, 0, got);
        host.close;
        counts(32'h06050101);
        op_busy = 1'h1;
        op_fail = 1'h1;
        saw_oe = 1'h0;
        host.open(0);
        host.xfer(8'h03, 8, 1, 0, got);
        host.xfer(a, 24, 1, 0, got);
        host.xfer(0, 16, 1, 1, got);
        host.close;
        check(saw_oe, 0);
        host.open(0);
        host.xfer(8'h05, 8, 1, 0, got);
        host.xfer(0, 16, 1, 1, got);
        host.close;
        check(got[15:0], 16'h0303);
        counts(32'h07060101);
        give_verdict;
    end
endmodule // sfcf_frame_bench
bind sfcf_frame sfcf_frame_assertions sfcf_frame_assertions_inst (.clock, .srst, .spi_clk,
    .select_n, .data_lane_0_oe, .data_lane_1_oe, .data_lane_2_oe, .data_lane_3_oe,
    .data_lane_1_out, .rd_ready, .cmd_start, .cmd_done, .cmd_reject, .wr_overrun, .wr_valid,
    .wr_ready, .wr_byte, .cmd_opcode, .cmd_addr);
